// >>> dmr_regs_defs.vh
`ifndef DMR_REGS_DEFS_VH
`define DMR_REGS_DEFS_VH

// register byte offsets inside the 128-byte window
`define DMR_ADDR_W        7
`define DMR_OFF_CTL       7'h00
`define DMR_OFF_STS       7'h04
`define DMR_OFF_CUR       7'h08
`define DMR_OFF_TAIL      7'h10
`define DMR_OFF_SRC       7'h18
`define DMR_OFF_DST       7'h20
`define DMR_OFF_BTT       7'h28

// control field positions
`define DMR_CTL_DLY_HI    31
`define DMR_CTL_DLY_LO    24
`define DMR_CTL_THR_HI    23
`define DMR_CTL_THR_LO    16
`define DMR_CTL_ERR_EN    14
`define DMR_CTL_DLY_EN    13
`define DMR_CTL_IOC_EN    12
`define DMR_CTL_CHAIN     3
`define DMR_CTL_SRST      2

// status field positions
`define DMR_STS_ERR       14
`define DMR_STS_DLY       13
`define DMR_STS_IOC       12

// reset values
`define DMR_DLY_RST       8'h00
`define DMR_THR_RST       8'h01
`define DMR_THR_ZERO      8'h00
`define DMR_IDLE_RST      1'b0
`define DMR_WORD_RST      32'h0000_0000

// delay tick resolution in clock cycles
`define DMR_TICK_DEF      256
`define DMR_TICK_W        17

// bus answers
`define DMR_RESP_OKAY     2'b00

`endif

// >>> dmr_tick_div.v
`timescale 1ns/1ps
`default_nettype none
`include "dmr_regs_defs.vh"

module dmr_tick_div #(
	parameter TICK_CYCLES = `DMR_TICK_DEF
) (
	// clock and reset
	input  wire                   ref_clk,
	input  wire                   arst_n,
	// control and tick
	input  wire                   run,
	output wire                   tick
);

	// the count range needs 17 bits, so the upper bits are cut on purpose
	localparam integer           LAST_I = TICK_CYCLES - 1;
	localparam [`DMR_TICK_W-1:0] LAST   = LAST_I[`DMR_TICK_W-1:0];

	reg [`DMR_TICK_W-1:0] cnt_ff;

	assign tick = run & (cnt_ff == LAST);

	// restarting on every stop keeps the first tick a full period away
	always @(posedge ref_clk or negedge arst_n)
	if (!arst_n)
	begin
		cnt_ff <= {`DMR_TICK_W{1'b0}};
	end
	else if (!run || tick)
	begin
		cnt_ff <= {`DMR_TICK_W{1'b0}};
	end
	else
	begin
		cnt_ff <= cnt_ff + 1'b1;
	end

endmodule
`default_nettype wire

// >>> dmr_ctrl_regs.v
// Operation
// - control 00, status 04, pointers 08/10, addresses 18/20, count 28
// - registers are 32 bits; window decoded on a 128-byte boundary
// - little-endian: byte lane 0 is the least significant byte
// - delay timer ticks every configured number of clocks, chain mode only
// - delay timeout field 31..24, resets to zero, zero disables it
// - delay timer counts only while idle, raises delay event at timeout
// - threshold 23..16 resets to 01h, counts down completions to zero
// - writing zero to the threshold leaves it unchanged
// - without chain support threshold resets and reads as zero
// - bits 14,13,12 enable error, delay, completion interrupts
// - delay enable sets only while chain mode is already one
// - bit 3 selects chain mode, only when chain support is built
// - chain mode off then on reloads the current descriptor pointer
// - bit 2 starts graceful soft reset, reads one until done
// - bit 1 reads one with chain support, zero otherwise
// - reserved bits ignore writes and read as zero
// - status shows live delay timer and threshold countdown
// - error flag sets on error event, write one clears it
// - delay flag sets on timeout, cleared by write one or chain off
// - completion flag sets on transfer done, in chain mode at threshold
// - written one clears a flag, written zero leaves it
// - idle bit; single mode byte count write starts, done sets idle
// - chain mode idle when tail reached; tail write restarts
`timescale 1ns/1ps
`default_nettype none
`include "dmr_regs_defs.vh"

module dmr_ctrl_regs #(
	parameter CHAIN_INC   = 1,
	parameter TICK_CYCLES = `DMR_TICK_DEF
) (
	// clock and reset
	input  wire                   ref_clk,
	input  wire                   arst_n,
	// lite slave write
	input  wire [31:0]            s_axi_lite_awaddr,
	input  wire                   s_axi_lite_awvalid,
	output wire                   s_axi_lite_awready,
	input  wire [31:0]            s_axi_lite_wdata,
	input  wire [3:0]             s_axi_lite_wstrb,
	input  wire                   s_axi_lite_wvalid,
	output wire                   s_axi_lite_wready,
	output wire [1:0]             s_axi_lite_bresp,
	output wire                   s_axi_lite_bvalid,
	input  wire                   s_axi_lite_bready,
	// lite slave read
	input  wire [31:0]            s_axi_lite_araddr,
	input  wire                   s_axi_lite_arvalid,
	output wire                   s_axi_lite_arready,
	output wire [31:0]            s_axi_lite_rdata,
	output wire [1:0]             s_axi_lite_rresp,
	output wire                   s_axi_lite_rvalid,
	input  wire                   s_axi_lite_rready,
	// engine events
	input  wire                   completion_event,
	input  wire                   error_event,
	input  wire                   chain_done_event,
	input  wire                   soft_reset_done,
	// engine control
	output wire [31:0]            source_address,
	output wire [31:0]            destination_address,
	output wire [31:0]            byte_count,
	output wire [31:0]            current_descriptor_pointer,
	output wire [31:0]            tail_descriptor_pointer,
	output wire                   chain_mode_select,
	output wire                   single_start,
	output wire                   chain_start,
	output wire                   desc_reload,
	output wire                   soft_reset_req,
	output wire                   intr_out
);

	localparam       SG      = (CHAIN_INC != 0);
	localparam [7:0] THR_RST = SG ? `DMR_THR_RST : `DMR_THR_ZERO;

	reg  [7:0]  ctl_dly_to_ff;
	reg  [7:0]  ctl_thr_ff;
	reg         ctl_err_en_ff;
	reg         ctl_dly_en_ff;
	reg         ctl_ioc_en_ff;
	reg         ctl_chain_ff;
	reg         ctl_srst_ff;
	reg         st_err_ff;
	reg         st_dly_ff;
	reg         st_ioc_ff;
	reg         st_idle_ff;
	reg  [7:0]  thr_cnt_ff;
	reg  [7:0]  dly_cnt_ff;
	reg  [31:0] cur_ff;
	reg  [31:0] tail_ff;
	reg  [31:0] src_ff;
	reg  [31:0] dst_ff;
	reg  [31:0] btt_ff;
	reg         bvalid_ff;
	reg         rvalid_ff;
	reg  [31:0] rdata_ff;
	reg         single_start_ff;
	reg         chain_start_ff;
	reg         desc_reload_ff;
	reg         intr_ff;
	reg  [31:0] nxt_rdata;

	wire [31:0] wmask;
	wire [31:0] ctl_word;
	wire [31:0] sts_word;
	wire [31:0] ctl_new;
	wire        wr_go;
	wire        rd_go;
	wire [`DMR_ADDR_W-1:0] wr_off;
	wire [`DMR_ADDR_W-1:0] rd_off;
	wire        wr_ctl;
	wire        wr_sts;
	wire        nv_chain;
	wire        chain_fall;
	wire        chain_rise;
	wire        thr_wr;
	wire        srst_clr;
	wire        dly_run;
	wire        tick;
	wire        dly_hit;
	wire        thr_hit;
	wire        ioc_set;
	wire        idle_set;
	wire        idle_clr;

	// little-endian lanes
	// wstrb bit n guards byte n, bits 8n+7..8n
	assign wmask = {{8{s_axi_lite_wstrb[3]}}, {8{s_axi_lite_wstrb[2]}},
		{8{s_axi_lite_wstrb[1]}}, {8{s_axi_lite_wstrb[0]}}};

	function [31:0] merge;
		input [31:0] old;
		input [31:0] dat;
		input [31:0] msk;
		begin
			merge = (old & ~msk) | (dat & msk);
		end
	endfunction

	// one write in flight; the answer must be taken before the next
	assign wr_go = s_axi_lite_awvalid & s_axi_lite_wvalid & ~bvalid_ff;
	assign rd_go = s_axi_lite_arvalid & ~rvalid_ff;
	assign s_axi_lite_awready = wr_go;
	assign s_axi_lite_wready  = wr_go;
	assign s_axi_lite_arready = rd_go;
	assign s_axi_lite_bvalid  = bvalid_ff;
	assign s_axi_lite_rvalid  = rvalid_ff;
	assign s_axi_lite_rdata   = rdata_ff;
	assign s_axi_lite_bresp   = `DMR_RESP_OKAY;
	assign s_axi_lite_rresp   = `DMR_RESP_OKAY;

	// 128-byte window
	// address bits above the window belong to the system decoder
	assign wr_off = {s_axi_lite_awaddr[`DMR_ADDR_W-1:2], 2'b00};
	assign rd_off = {s_axi_lite_araddr[`DMR_ADDR_W-1:2], 2'b00};

	assign wr_ctl = wr_go & (wr_off == `DMR_OFF_CTL);
	assign wr_sts = wr_go & (wr_off == `DMR_OFF_STS);

	assign ctl_word = {ctl_dly_to_ff, ctl_thr_ff, 1'b0, ctl_err_en_ff,
		ctl_dly_en_ff, ctl_ioc_en_ff, 8'h00, ctl_chain_ff, ctl_srst_ff,
		SG ? 1'b1 : 1'b0, 1'b0};

	assign sts_word = {dly_cnt_ff, thr_cnt_ff, 1'b0, st_err_ff, st_dly_ff,
		st_ioc_ff, 8'h00, SG ? 1'b1 : 1'b0, 1'b0, st_idle_ff, 1'b0};

	assign ctl_new = merge(ctl_word, s_axi_lite_wdata, wmask);

	assign nv_chain   = ctl_new[`DMR_CTL_CHAIN] & SG;
	assign chain_fall = wr_ctl & ctl_chain_ff & ~nv_chain;
	assign chain_rise = wr_ctl & ~ctl_chain_ff & nv_chain;

	assign thr_wr = wr_ctl & s_axi_lite_wstrb[2] & SG &
		(s_axi_lite_wdata[`DMR_CTL_THR_HI:`DMR_CTL_THR_LO] != 8'h00);

	// registers return to reset once the engine has drained
	assign srst_clr = ctl_srst_ff & soft_reset_done;

	assign dly_run = ctl_chain_ff & st_idle_ff &
		(ctl_dly_to_ff != 8'h00) & ~completion_event;

	dmr_tick_div #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.run     (dly_run),
		.tick    (tick)
	);

	assign dly_hit = tick & (dly_cnt_ff + 8'h01 == ctl_dly_to_ff);

	assign thr_hit = completion_event & ctl_chain_ff & (thr_cnt_ff <= 8'h01);

	assign ioc_set = completion_event & (~ctl_chain_ff | thr_hit);

	assign idle_clr = (wr_go & (wr_off == `DMR_OFF_BTT) & ~ctl_chain_ff) |
		(wr_go & (wr_off == `DMR_OFF_TAIL) & ctl_chain_ff);
	assign idle_set = (completion_event & ~ctl_chain_ff) |
		(chain_done_event & ctl_chain_ff) | error_event;

	// control register
	always @(posedge ref_clk or negedge arst_n)
	if (!arst_n)
	begin
		ctl_dly_to_ff <= `DMR_DLY_RST;
		ctl_thr_ff    <= THR_RST;
		ctl_err_en_ff <= 1'b0;
		ctl_dly_en_ff <= 1'b0;
		ctl_ioc_en_ff <= 1'b0;
		ctl_chain_ff  <= 1'b0;
		ctl_srst_ff   <= 1'b0;
	end
	else if (srst_clr)
	begin
		ctl_dly_to_ff <= `DMR_DLY_RST;
		ctl_thr_ff    <= THR_RST;
		ctl_err_en_ff <= 1'b0;
		ctl_dly_en_ff <= 1'b0;
		ctl_ioc_en_ff <= 1'b0;
		ctl_chain_ff  <= 1'b0;
		ctl_srst_ff   <= 1'b0;
	end
	else if (wr_ctl)
	begin
		ctl_dly_to_ff <= ctl_new[`DMR_CTL_DLY_HI:`DMR_CTL_DLY_LO];
		if (thr_wr)
			ctl_thr_ff <= s_axi_lite_wdata[`DMR_CTL_THR_HI:`DMR_CTL_THR_LO];
		ctl_err_en_ff <= ctl_new[`DMR_CTL_ERR_EN];
		ctl_ioc_en_ff <= ctl_new[`DMR_CTL_IOC_EN];
		ctl_dly_en_ff <= ctl_new[`DMR_CTL_DLY_EN] & ctl_chain_ff;
		ctl_chain_ff  <= nv_chain;
		ctl_srst_ff   <= ctl_srst_ff | ctl_new[`DMR_CTL_SRST];
	end

	// status flags; a hardware set beats a same-cycle write-one clear
	always @(posedge ref_clk or negedge arst_n)
	if (!arst_n)
	begin
		st_err_ff  <= 1'b0;
		st_dly_ff  <= 1'b0;
		st_ioc_ff  <= 1'b0;
		st_idle_ff <= `DMR_IDLE_RST;
	end
	else if (srst_clr)
	begin
		st_err_ff  <= 1'b0;
		st_dly_ff  <= 1'b0;
		st_ioc_ff  <= 1'b0;
		st_idle_ff <= `DMR_IDLE_RST;
	end
	else
	begin
		if (error_event)
			st_err_ff <= 1'b1;
		else if (wr_sts & wmask[`DMR_STS_ERR] &
			s_axi_lite_wdata[`DMR_STS_ERR])
			st_err_ff <= 1'b0;
		// delay flag, also dropped when chain mode is written off
		if (dly_hit)
			st_dly_ff <= 1'b1;
		else if (chain_fall | (wr_sts & wmask[`DMR_STS_DLY] &
			s_axi_lite_wdata[`DMR_STS_DLY]))
			st_dly_ff <= 1'b0;
		if (ioc_set)
			st_ioc_ff <= 1'b1;
		else if (wr_sts & wmask[`DMR_STS_IOC] &
			s_axi_lite_wdata[`DMR_STS_IOC])
			st_ioc_ff <= 1'b0;
		if (idle_set)
			st_idle_ff <= 1'b1;
		else if (idle_clr)
			st_idle_ff <= 1'b0;
	end

	// coalescing counters
	always @(posedge ref_clk or negedge arst_n)
	if (!arst_n)
	begin
		thr_cnt_ff <= THR_RST;
		dly_cnt_ff <= `DMR_DLY_RST;
	end
	else if (srst_clr)
	begin
		thr_cnt_ff <= THR_RST;
		dly_cnt_ff <= `DMR_DLY_RST;
	end
	else
	begin
		if (thr_wr)
			thr_cnt_ff <= s_axi_lite_wdata[`DMR_CTL_THR_HI:`DMR_CTL_THR_LO];
		else if (thr_hit)
			thr_cnt_ff <= ctl_thr_ff;
		else if (completion_event & ctl_chain_ff)
			thr_cnt_ff <= thr_cnt_ff - 8'h01;
		// count ticks up to the timeout
		if (!dly_run || dly_hit)
			dly_cnt_ff <= `DMR_DLY_RST;
		else if (tick)
			dly_cnt_ff <= dly_cnt_ff + 8'h01;
	end

	always @(posedge ref_clk or negedge arst_n)
	if (!arst_n)
	begin
		cur_ff  <= `DMR_WORD_RST;
		tail_ff <= `DMR_WORD_RST;
		src_ff  <= `DMR_WORD_RST;
		dst_ff  <= `DMR_WORD_RST;
		btt_ff  <= `DMR_WORD_RST;
	end
	else if (srst_clr)
	begin
		cur_ff  <= `DMR_WORD_RST;
		tail_ff <= `DMR_WORD_RST;
		src_ff  <= `DMR_WORD_RST;
		dst_ff  <= `DMR_WORD_RST;
		btt_ff  <= `DMR_WORD_RST;
	end
	else if (wr_go)
	begin
		if (wr_off == `DMR_OFF_CUR)
			cur_ff <= merge(cur_ff, s_axi_lite_wdata, wmask);
		if (wr_off == `DMR_OFF_TAIL)
			tail_ff <= merge(tail_ff, s_axi_lite_wdata, wmask);
		if (wr_off == `DMR_OFF_SRC)
			src_ff <= merge(src_ff, s_axi_lite_wdata, wmask);
		if (wr_off == `DMR_OFF_DST)
			dst_ff <= merge(dst_ff, s_axi_lite_wdata, wmask);
		if (wr_off == `DMR_OFF_BTT)
			btt_ff <= merge(btt_ff, s_axi_lite_wdata, wmask);
	end

	// gaps and unmapped offsets read zero
	always @*
	begin
		nxt_rdata = `DMR_WORD_RST;
		case (rd_off)
			`DMR_OFF_CTL:  nxt_rdata = ctl_word;
			`DMR_OFF_STS:  nxt_rdata = sts_word;
			`DMR_OFF_CUR:  nxt_rdata = cur_ff;
			`DMR_OFF_TAIL: nxt_rdata = tail_ff;
			`DMR_OFF_SRC:  nxt_rdata = src_ff;
			`DMR_OFF_DST:  nxt_rdata = dst_ff;
			`DMR_OFF_BTT:  nxt_rdata = btt_ff;
			default:       nxt_rdata = `DMR_WORD_RST;
		endcase
	end

	// bus answers, pulses and interrupt
	always @(posedge ref_clk or negedge arst_n)
	if (!arst_n)
	begin
		bvalid_ff       <= 1'b0;
		rvalid_ff       <= 1'b0;
		rdata_ff        <= `DMR_WORD_RST;
		single_start_ff <= 1'b0;
		chain_start_ff  <= 1'b0;
		desc_reload_ff  <= 1'b0;
		intr_ff         <= 1'b0;
	end
	else
	begin
		if (wr_go)
			bvalid_ff <= 1'b1;
		else if (s_axi_lite_bready)
			bvalid_ff <= 1'b0;
		if (rd_go)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= nxt_rdata;
		end
		else if (s_axi_lite_rready)
			rvalid_ff <= 1'b0;
		single_start_ff <= wr_go & (wr_off == `DMR_OFF_BTT) & ~ctl_chain_ff;
		chain_start_ff  <= wr_go & (wr_off == `DMR_OFF_TAIL) & ctl_chain_ff;
		desc_reload_ff  <= chain_rise;
		intr_ff <= (st_err_ff & ctl_err_en_ff) | (st_dly_ff & ctl_dly_en_ff) |
			(st_ioc_ff & ctl_ioc_en_ff);
	end

	assign source_address             = src_ff;
	assign destination_address        = dst_ff;
	assign byte_count                 = btt_ff;
	assign current_descriptor_pointer = cur_ff;
	assign tail_descriptor_pointer    = tail_ff;
	assign chain_mode_select          = ctl_chain_ff;
	assign single_start               = single_start_ff;
	assign chain_start                = chain_start_ff;
	assign desc_reload                = desc_reload_ff;
	assign soft_reset_req             = ctl_srst_ff;
	assign intr_out                   = intr_ff;

endmodule
`default_nettype wire

// >>> dmr_ctrl_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dmr_ctrl_regs_monitor #(
	parameter CHAIN_INC   = 1,
	parameter TICK_CYCLES = 256
) (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        arst_n,
	// lite bus
	input wire logic [31:0] s_axi_lite_awaddr,
	input wire logic        s_axi_lite_awvalid,
	input wire logic        s_axi_lite_awready,
	input wire logic [31:0] s_axi_lite_wdata,
	input wire logic [3:0]  s_axi_lite_wstrb,
	input wire logic        s_axi_lite_wvalid,
	input wire logic [1:0]  s_axi_lite_bresp,
	input wire logic        s_axi_lite_bvalid,
	input wire logic        s_axi_lite_arvalid,
	input wire logic        s_axi_lite_arready,
	input wire logic [1:0]  s_axi_lite_rresp,
	input wire logic        s_axi_lite_rvalid,
	// engine side
	input wire logic        soft_reset_done,
	input wire logic        chain_mode_select,
	input wire logic        single_start,
	input wire logic        chain_start,
	input wire logic        desc_reload,
	input wire logic        soft_reset_req
);
	wire       wr_ok;
	wire [4:0] wsel;
	wire       ctl_wr;
	wire       btt_wr;
	assign wr_ok  = s_axi_lite_awvalid && s_axi_lite_wvalid
		&& !s_axi_lite_bvalid;
	assign wsel   = s_axi_lite_awaddr[6:2];
	assign ctl_wr = wr_ok && wsel == 5'h00 && s_axi_lite_wstrb[0];
	assign btt_wr = wr_ok && wsel == 5'h0a && !chain_mode_select;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	sequence s_pulse(sig);
		sig ##1 !sig;
	endsequence
	sequence s_rd_taken;
		s_axi_lite_arvalid && !s_axi_lite_rvalid;
	endsequence

	a_write_answer: assert property (
		wr_ok |=> s_axi_lite_bvalid && s_axi_lite_bresp == 2'b00)
		else $error("write not answered next cycle");
	a_read_answer: assert property (
		s_rd_taken |=> s_axi_lite_rvalid && s_axi_lite_rresp == 2'b00)
		else $error("read not answered next cycle");
	a_busy_refuse: assert property (
		(s_axi_lite_bvalid |-> !s_axi_lite_awready)
		and (s_axi_lite_rvalid |-> !s_axi_lite_arready))
		else $error("request accepted while answer pending");
	a_single_go: assert property (
		btt_wr |=> s_pulse(single_start))
		else $error("byte count write did not start transfer");
	a_start_cause: assert property (
		single_start |-> $past(btt_wr))
		else $error("transfer started without byte count write");
	a_chain_go: assert property (
		wr_ok && wsel == 5'h04 && chain_mode_select |=> s_pulse(chain_start))
		else $error("tail write did not restart chain");
	a_chain_reload: assert property (
		CHAIN_INC != 0 &&
		ctl_wr && s_axi_lite_wdata[3] && !chain_mode_select && !soft_reset_req
		|=> desc_reload && chain_mode_select)
		else $error("chain re-entry did not reload pointer");
	a_srst_set: assert property (
		ctl_wr && s_axi_lite_wdata[2] && !soft_reset_done |=> soft_reset_req)
		else $error("soft reset not raised");
	a_srst_hold: assert property (
		soft_reset_req && !soft_reset_done |=> soft_reset_req)
		else $error("soft reset dropped before drain");
	a_srst_done: assert property (
		soft_reset_req && soft_reset_done && !wr_ok
		|=> !soft_reset_req && !chain_mode_select)
		else $error("soft reset did not complete");
endmodule

bind dmr_ctrl_regs dmr_ctrl_regs_monitor #(
	.CHAIN_INC  (CHAIN_INC),
	.TICK_CYCLES(TICK_CYCLES)
) u_dmr_ctrl_regs_monitor (
	.ref_clk, .arst_n, .s_axi_lite_awaddr, .s_axi_lite_awvalid,
	.s_axi_lite_awready, .s_axi_lite_wdata, .s_axi_lite_wstrb,
	.s_axi_lite_wvalid, .s_axi_lite_bresp, .s_axi_lite_bvalid,
	.s_axi_lite_arvalid, .s_axi_lite_arready, .s_axi_lite_rresp,
	.s_axi_lite_rvalid, .soft_reset_done, .chain_mode_select, .single_start,
	.chain_start, .desc_reload, .soft_reset_req
);
`default_nettype wire

// >>> dmr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmr_host_model #(
	// any multiple of 128 bytes works
	parameter logic [31:0] REGISTER_BASE = 32'h0000_0f80
) (
	// clock
	input  wire logic        ref_clk,
	// write channels
	output var  logic [31:0] s_axi_lite_awaddr,
	output var  logic        s_axi_lite_awvalid,
	input  wire logic        s_axi_lite_awready,
	output var  logic [31:0] s_axi_lite_wdata,
	output var  logic [3:0]  s_axi_lite_wstrb,
	output var  logic        s_axi_lite_wvalid,
	input  wire logic        s_axi_lite_wready,
	input  wire logic        s_axi_lite_bvalid,
	output var  logic        s_axi_lite_bready,
	// read channels
	output var  logic [31:0] s_axi_lite_araddr,
	output var  logic        s_axi_lite_arvalid,
	input  wire logic        s_axi_lite_arready,
	input  wire logic [31:0] s_axi_lite_rdata,
	input  wire logic        s_axi_lite_rvalid,
	output var  logic        s_axi_lite_rready,
	// stuck handshakes seen
	output var  integer      hang
);
	initial
	begin
		{s_axi_lite_awaddr, s_axi_lite_wdata, s_axi_lite_araddr} = '0;
		{s_axi_lite_awvalid, s_axi_lite_wvalid, s_axi_lite_arvalid} = '0;
		s_axi_lite_wstrb  = 4'h0;
		s_axi_lite_bready = 1'b1;
		s_axi_lite_rready = 1'b1;
		hang              = 0;
	end
	// callers enter just after an edge; requests hold until taken or until 8 ready checks fail
	task wr(input logic [6:0] off, input logic [31:0] d, input logic [3:0] s);
		integer n;
		begin
			s_axi_lite_awaddr  = REGISTER_BASE | {25'h0, off};
			s_axi_lite_wdata   = d;
			s_axi_lite_wstrb   = s;
			s_axi_lite_awvalid = 1'b1;
			s_axi_lite_wvalid  = 1'b1;
			// ready is judged mid-cycle, where it has settled for the edge
			for (n = 0; n < 8; n++)
			begin
				@(negedge ref_clk);
				if (s_axi_lite_awready && s_axi_lite_wready)
					break;
			end
			hang += (n == 8);
			@(posedge ref_clk) #1;
			s_axi_lite_awvalid = 1'b0;
			s_axi_lite_wvalid  = 1'b0;
			s_axi_lite_wdata   = ~d;
			for (n = 0; n < 8 && !s_axi_lite_bvalid; n++)
				@(posedge ref_clk) #1;
			hang += (n == 8);
			@(posedge ref_clk) #1;
		end
	endtask
	task rd(input logic [6:0] off, output logic [31:0] d);
		integer n;
		begin
			s_axi_lite_araddr  = REGISTER_BASE | {25'h0, off};
			s_axi_lite_arvalid = 1'b1;
			for (n = 0; n < 8; n++)
			begin
				@(negedge ref_clk);
				if (s_axi_lite_arready)
					break;
			end
			hang += (n == 8);
			@(posedge ref_clk) #1;
			s_axi_lite_arvalid = 1'b0;
			for (n = 0; n < 8 && !s_axi_lite_rvalid; n++)
				@(posedge ref_clk) #1;
			hang += (n == 8);
			d = s_axi_lite_rdata;
			@(posedge ref_clk) #1;
		end
	endtask
endmodule
`default_nettype wire

// >>> dmr_ctrl_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmr_regs_defs.vh"
`define CHK(g, e, m) \
	begin \
		checks++; \
		if ((g) !== (e)) \
		begin \
			mismatches++; \
			$display("CHECK FAILED %0t %s got %h", $time, m, g); \
		end \
	end
module dmr_ctrl_regs_test;
	logic        ref_clk, arst_n;
	logic        completion_event, error_event, chain_done_event;
	logic        soft_reset_done;
	integer      checks, mismatches, i;
	logic [31:0] st;
	wire  [31:0] s_axi_lite_awaddr, s_axi_lite_wdata, s_axi_lite_araddr;
	wire  [31:0] s_axi_lite_rdata, source_address, destination_address;
	wire  [31:0] byte_count, current_descriptor_pointer;
	wire  [31:0] tail_descriptor_pointer;
	wire  [3:0]  s_axi_lite_wstrb;
	wire         s_axi_lite_awvalid, s_axi_lite_wvalid, s_axi_lite_bready;
	wire         s_axi_lite_arvalid, s_axi_lite_rready, s_axi_lite_awready;
	wire         s_axi_lite_wready, s_axi_lite_bvalid, s_axi_lite_arready;
	wire         s_axi_lite_rvalid, chain_mode_select, single_start;
	wire         chain_start, desc_reload, soft_reset_req, intr_out;

	dmr_ctrl_regs #(
		.CHAIN_INC  (1),
		.TICK_CYCLES(2)
	) u_dmr_ctrl_regs (
		.ref_clk, .arst_n, .s_axi_lite_awaddr, .s_axi_lite_awvalid,
		.s_axi_lite_awready, .s_axi_lite_wdata, .s_axi_lite_wstrb,
		.s_axi_lite_wvalid, .s_axi_lite_wready, .s_axi_lite_bresp(),
		.s_axi_lite_bvalid, .s_axi_lite_bready, .s_axi_lite_araddr,
		.s_axi_lite_arvalid, .s_axi_lite_arready, .s_axi_lite_rdata,
		.s_axi_lite_rresp(), .s_axi_lite_rvalid, .s_axi_lite_rready,
		.completion_event, .error_event, .chain_done_event, .soft_reset_done,
		.source_address, .destination_address, .byte_count,
		.current_descriptor_pointer, .tail_descriptor_pointer,
		.chain_mode_select, .single_start, .chain_start, .desc_reload,
		.soft_reset_req, .intr_out
	);
	dmr_host_model u_dmr_host_model (
		.ref_clk, .s_axi_lite_awaddr, .s_axi_lite_awvalid, .s_axi_lite_awready,
		.s_axi_lite_wdata, .s_axi_lite_wstrb, .s_axi_lite_wvalid,
		.s_axi_lite_wready, .s_axi_lite_bvalid, .s_axi_lite_bready,
		.s_axi_lite_araddr, .s_axi_lite_arvalid, .s_axi_lite_arready,
		.s_axi_lite_rdata, .s_axi_lite_rvalid, .s_axi_lite_rready, .hang()
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task end_of_test;
		begin
			mismatches += u_dmr_host_model.hang;
			$display("checks %0d mismatches %0d", checks, mismatches);
			if (mismatches == 0 && checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task wr(input logic [6:0] o, input logic [31:0] d, input logic [3:0] s = 4'hf);
		begin
			u_dmr_host_model.wr(o, d, s);
			if (u_dmr_host_model.hang != 0)
				end_of_test;
		end
	endtask
	task rd(input logic [6:0] o);
		begin
			u_dmr_host_model.rd(o, st);
			if (u_dmr_host_model.hang != 0)
				end_of_test;
		end
	endtask
	task automatic pulse(ref logic s);
		begin
			s = 1'b1;
			@(posedge ref_clk) #1;
			s = 1'b0;
		end
	endtask

	task t_reset;
		begin
			rd(`DMR_OFF_CTL);
			`CHK(st, 32'h0001_0002, "ctrl reset")
			rd(`DMR_OFF_STS);
			`CHK(st, 32'h0001_0008, "status reset")
			rd(7'h0c);
			`CHK(st, 32'h0, "gap read")
		end
	endtask
	task t_regs;
		logic [6:0] offs [4];
		begin
			offs = '{`DMR_OFF_CUR, `DMR_OFF_TAIL, `DMR_OFF_SRC, `DMR_OFF_DST};
			for (i = 0; i < 4; i++)
			begin
				wr(offs[i], 32'ha5c3_0000 | {25'h0, offs[i]});
				rd(offs[i]);
				`CHK(st, 32'ha5c3_0000 | {25'h0, offs[i]}, "rw reg")
			end
			`CHK(tail_descriptor_pointer, 32'ha5c3_0010, "tail port")
			`CHK(current_descriptor_pointer, 32'ha5c3_0008, "cur port")
			`CHK(destination_address, 32'ha5c3_0020, "dst port")
			// only byte lane 1 may change
			wr(`DMR_OFF_SRC, 32'hffff_3cff, 4'b0010);
			rd(`DMR_OFF_SRC);
			`CHK(st, 32'ha5c3_3c18, "byte lane")
			`CHK(source_address, 32'ha5c3_3c18, "src port")
		end
	endtask
	task t_ctrl;
		begin
			// reach idle before the mode bit is changed
			pulse(completion_event);
			wr(`DMR_OFF_STS, 32'h0000_1000);
			wr(`DMR_OFF_CTL, 32'hffff_fffb);
			rd(`DMR_OFF_CTL);
			`CHK(st, 32'hffff_500a, "ctrl all ones")
			`CHK(chain_mode_select, 1'b1, "chain port")
			wr(`DMR_OFF_CTL, 32'hffff_fffb);
			rd(`DMR_OFF_CTL);
			`CHK(st, 32'hffff_700a, "delay enable")
			wr(`DMR_OFF_CTL, 32'h0000_7008);
			rd(`DMR_OFF_CTL);
			`CHK(st, 32'h00ff_700a, "zero threshold")
		end
	endtask
	task t_coal;
		begin
			wr(`DMR_OFF_CTL, 32'h0002_7008);
			rd(`DMR_OFF_STS);
			`CHK(st & 32'h00ff_7000, 32'h0002_0000, "reload")
			pulse(completion_event);
			rd(`DMR_OFF_STS);
			`CHK(st & 32'h00ff_7000, 32'h0001_0000, "count down")
			pulse(completion_event);
			rd(`DMR_OFF_STS);
			`CHK(st & 32'h00ff_7000, 32'h0002_1000, "threshold met")
			`CHK(intr_out, 1'b1, "irq on")
			wr(`DMR_OFF_STS, 32'h0);
			rd(`DMR_OFF_STS);
			`CHK(st[12], 1'b1, "zero keeps")
			wr(`DMR_OFF_STS, 32'h0000_1000);
			rd(`DMR_OFF_STS);
			`CHK(st[12], 1'b0, "one clears")
			`CHK(intr_out, 1'b0, "irq off")
		end
	endtask
	task t_delay;
		begin
			wr(`DMR_OFF_CTL, 32'h0202_7008);
			pulse(chain_done_event);
			st = 32'h0;
			for (i = 0; i < 8 && st[13] !== 1'b1; i++)
				rd(`DMR_OFF_STS);
			`CHK(st[13], 1'b1, "delay timeout")
			`CHK(st[1], 1'b1, "chain idle")
			`CHK(intr_out, 1'b1, "delay irq")
			wr(`DMR_OFF_TAIL, 32'h0000_0200);
			rd(`DMR_OFF_STS);
			`CHK(st[1], 1'b0, "tail restart")
			// mode is only changed while idle, with the timer off first
			pulse(chain_done_event);
			wr(`DMR_OFF_CTL, 32'h0002_7008);
			wr(`DMR_OFF_CTL, 32'h0002_5000);
			rd(`DMR_OFF_STS);
			`CHK(st[13], 1'b0, "chain off clears")
		end
	endtask
	task t_single;
		begin
			wr(`DMR_OFF_BTT, 32'h0000_0100);
			`CHK(byte_count, 32'h0000_0100, "count port")
			rd(`DMR_OFF_STS);
			`CHK(st[1], 1'b0, "busy")
			pulse(completion_event);
			rd(`DMR_OFF_STS);
			`CHK(st & 32'h0000_5002, 32'h0000_1002, "done")
			pulse(error_event);
			rd(`DMR_OFF_STS);
			`CHK(st & 32'h0000_5002, 32'h0000_5002, "error")
			wr(`DMR_OFF_STS, 32'h0000_4000);
			rd(`DMR_OFF_STS);
			`CHK(st & 32'h0000_5000, 32'h0000_1000, "err clear")
			`CHK(intr_out, 1'b1, "irq held")
		end
	endtask
	task t_soft;
		begin
			wr(`DMR_OFF_CTL, 32'h0000_0004);
			rd(`DMR_OFF_CTL);
			`CHK(st, 32'h0002_0006, "reset busy")
			pulse(soft_reset_done);
			rd(`DMR_OFF_CTL);
			`CHK(st, 32'h0001_0002, "reset done")
			rd(`DMR_OFF_STS);
			`CHK(st, 32'h0001_0008, "status cleared")
			`CHK(source_address, 32'h0, "src cleared")
			`CHK(intr_out, 1'b0, "irq cleared")
		end
	endtask

	initial
	begin
		checks           = 0;
		mismatches       = 0;
		st               = 32'h0;
		arst_n           = 1'b0;
		completion_event = 1'b0;
		error_event      = 1'b0;
		chain_done_event = 1'b0;
		soft_reset_done  = 1'b0;
		repeat (12) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		@(posedge ref_clk) #1;
		t_reset;
		t_regs;
		t_ctrl;
		t_coal;
		t_delay;
		t_single;
		t_soft;
		end_of_test;
	end
endmodule
`default_nettype wire
